// >>> src/stws_regs.svh
// Constants for the sensor two-wire slave with alert response
`ifndef STWS_REGS_SVH
`define STWS_REGS_SVH
`define STWS_ADDR_BASE 6'h24
`define STWS_GCALL_ADDR 7'h00
`define STWS_ARA_BYTE 8'h19
`define STWS_GC_LATCH 8'h04
`define STWS_GC_RESET 8'h06
`define STWS_CLK_HZ 10000000
`define STWS_TIMEOUT_MS 54
`define STWS_TIMEOUT_CYC ((`STWS_CLK_HZ / 1000) * `STWS_TIMEOUT_MS)
`endif

// >>> src/stws_pkg.sv
// Types for the sensor two-wire slave
package stws_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ACK,
		ST_RX,
		ST_TX,
		ST_TX_ACK
	} stws_state_t;
	typedef enum logic [1:0] {
		KIND_NONE,
		KIND_READ,
		KIND_ARA,
		KIND_GCALL
	} stws_kind_t;
endpackage

// >>> src/stws_stuck_timer.sv
// Bus-stuck timer: pulses when a line stays low too long inside a frame
`timescale 1ns/1ps
`include "stws_regs.svh"
module stws_stuck_timer #(
	parameter int unsigned LIMIT = `STWS_TIMEOUT_CYC
) (
	input wire logic clk_in, // System clock
	input wire logic rst_n_in, // Synchronous reset
	input wire logic run_in, // Frame active and a line is low
	output logic expire_out // One-cycle timeout pulse
);
	logic [31:0] cnt_q;
	logic [31:0] cnt_d;
	logic expire_d;
	logic expire_q;

	always_comb begin
		cnt_d = '0;
		expire_d = 1'b0;
		if (run_in) begin
			if (cnt_q == LIMIT - 1) begin
				expire_d = 1'b1; // see RL11
			end else begin
				cnt_d = cnt_q + 32'h1;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			cnt_q <= '0;
			expire_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			expire_q <= expire_d;
		end
	end

	assign expire_out = expire_q;

	expire_bound_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		expire_out |-> $past(run_in)) // see RL11
		else $error("timeout fired without a stuck line");
endmodule

// >>> src/stws_slave.sv
// Two-wire slave: reads, alert response, general call and timeout
// Rules from the document
// RL1 - Acknowledge own address before read data
// RL2 - Send upper byte, then lower byte
// RL3 - Master acknowledges; nack, start, stop end
// RL4 - Master sends alert response command
// RL5 - Alarm active: ack alert, return address
// RL6 - Alert address last bit gives limit side
// RL7 - Arbitrate address; winner clears alarm
// RL8 - Acknowledge general call, take command byte
// RL9 - Command 04 relatches address pin
// RL10 - Command 06 relatches and resets registers
// RL11 - Line low 54 ms in frame resets
// RL12 - After timeout release bus, await start
// RL13 - Master keeps clock at least 1 kHz
// RL14 - Start is SDA fall with SCL high
// RL15 - Stop is SDA rise with SCL high
// RL16 - Any byte count between start, stop
// RL17 - Ack holds SDA low on ninth pulse
// RL18 - Both lines high means idle bus
// RL19 - Read uses last written register index
// RL20 - Address 1001000 or 1001001 from pin
// RL21 - Alarm held until read or alert response
// RL22 - Ignore all other addresses
`timescale 1ns/1ps
`include "stws_regs.svh"
module stws_slave #(
	parameter int unsigned TIMEOUT_CYC = `STWS_TIMEOUT_CYC
) (
	input wire logic clk_in, // System clock, 10 MHz
	input wire logic rst_n_in, // Synchronous reset, active low
	input wire logic scl_in, // Bus clock level
	input wire logic sda_in, // Bus data level
	output logic sda_out, // Data drive value, always low
	output logic sda_oe_out, // High while pulling data low
	input wire logic address_select_pin_in, // Address select strap
	input wire logic [7:0] reg_index_in, // Last written register index
	input wire logic [15:0] reg_data_in, // Contents of indexed register
	input wire logic alarm_in, // Alarm output is active
	input wire logic alarm_high_in, // Alarm was from upper limit
	output logic reg_read_out, // Pulse: a register read began
	output logic alarm_clear_out, // Pulse: alert response won
	output logic regs_reset_out, // Pulse: general call reset
	output logic busy_out // Frame in progress
);
	stws_pkg::stws_state_t st_q, st_d;
	stws_pkg::stws_kind_t kind_q, kind_d;
	logic scl_q, sda_q;
	logic [7:0] sh_q, sh_d;
	logic [3:0] bit_q, bit_d;
	logic [15:0] tx_q, tx_d;
	logic byte2_q, byte2_d;
	logic busy_q, busy_d;
	logic pin_q, pin_d;
	logic oe_q, oe_d;
	logic lost_q, lost_d;
	logic gc_cmd_q, gc_cmd_d;
	logic rd_d, clr_d, rst_d;
	logic rd_q, clr_q, rst_q;
	logic start_ev, stop_ev, scl_rise, scl_fall, tmo;
	logic [6:0] my_addr;
	logic [7:0] byte_in;
	logic tmo_scl, tmo_sda;

	assign start_ev = scl_in && scl_q && sda_q && !sda_in; // see RL14
	assign stop_ev = scl_in && scl_q && !sda_q && sda_in; // see RL15
	assign scl_rise = scl_in && !scl_q;
	assign scl_fall = !scl_in && scl_q;
	assign my_addr = {`STWS_ADDR_BASE, pin_q}; // see RL20
	assign byte_in = {sh_q[6:0], sda_in};

	// One counter per line: a line that toggles resets only its own count
	stws_stuck_timer #(.LIMIT(TIMEOUT_CYC)) u_scl_timer (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.run_in(busy_q && !scl_in), // see RL11
		.expire_out(tmo_scl)
	);
	stws_stuck_timer #(.LIMIT(TIMEOUT_CYC)) u_sda_timer (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.run_in(busy_q && !sda_in), // see RL11
		.expire_out(tmo_sda)
	);
	assign tmo = tmo_scl || tmo_sda;

	always_comb begin
		st_d = st_q;
		kind_d = kind_q;
		sh_d = sh_q;
		bit_d = bit_q;
		tx_d = tx_q;
		byte2_d = byte2_q;
		busy_d = busy_q;
		pin_d = pin_q;
		oe_d = oe_q;
		lost_d = lost_q;
		gc_cmd_d = gc_cmd_q;
		rd_d = 1'b0;
		clr_d = 1'b0;
		rst_d = 1'b0;
		if (tmo) begin
			// Release and wait for a fresh start
			st_d = stws_pkg::ST_IDLE; // see RL12
			oe_d = 1'b0;
			busy_d = 1'b0;
		end else if (start_ev) begin
			// A repeated start also ends any read in progress
			st_d = stws_pkg::ST_ADDR; // see RL3
			busy_d = 1'b1;
			bit_d = 4'h0;
			oe_d = 1'b0;
			pin_d = address_select_pin_in; // see RL20
			kind_d = stws_pkg::KIND_NONE;
		end else if (stop_ev) begin
			st_d = stws_pkg::ST_IDLE; // see RL18
			busy_d = 1'b0;
			oe_d = 1'b0;
		end else begin
			unique case (st_q)
			stws_pkg::ST_IDLE: begin
				oe_d = 1'b0;
			end
			stws_pkg::ST_ADDR, stws_pkg::ST_RX: begin
				if (scl_rise) begin
					sh_d = byte_in;
					bit_d = bit_q + 4'h1;
				end
				if (scl_fall && bit_q == 4'h8) begin
					bit_d = 4'h0;
					st_d = stws_pkg::ST_ACK;
					oe_d = 1'b0;
					if (st_q == stws_pkg::ST_ADDR) begin
						if (sh_q == {my_addr, 1'b1}) begin
							kind_d = stws_pkg::KIND_READ;
							oe_d = 1'b1; // see RL1
						end else if (sh_q == `STWS_ARA_BYTE && alarm_in) begin
							kind_d = stws_pkg::KIND_ARA;
							oe_d = 1'b1; // see RL5
						end else if (sh_q == {`STWS_GCALL_ADDR, 1'b0}) begin
							kind_d = stws_pkg::KIND_GCALL;
							gc_cmd_d = 1'b0;
							oe_d = 1'b1; // see RL8
						end else begin
							st_d = stws_pkg::ST_IDLE; // see RL22
						end
					end else if (kind_q == stws_pkg::KIND_GCALL && !gc_cmd_q) begin
						gc_cmd_d = 1'b1;
						oe_d = 1'b1; // see RL17
						if (sh_q == `STWS_GC_LATCH) begin
							pin_d = address_select_pin_in; // see RL9
						end else if (sh_q == `STWS_GC_RESET) begin
							pin_d = address_select_pin_in; // see RL10
							rst_d = 1'b1;
						end
					end else begin
						// Bytes after the command are not ours to take
						st_d = stws_pkg::ST_IDLE;
					end
				end
			end
			stws_pkg::ST_ACK: begin
				if (scl_fall) begin
					oe_d = 1'b0;
					unique case (kind_q)
					stws_pkg::KIND_READ: begin
						tx_d = reg_data_in; // see RL19
						rd_d = 1'b1; // see RL21
						byte2_d = 1'b0;
						// A loss left over from an alert must not mute a read
						lost_d = 1'b0;
						st_d = stws_pkg::ST_TX;
						oe_d = !reg_data_in[15]; // see RL2
					end
					stws_pkg::KIND_ARA: begin
						tx_d = {my_addr, alarm_high_in, 8'h00}; // see RL6
						lost_d = 1'b0;
						st_d = stws_pkg::ST_TX;
						oe_d = !my_addr[6];
					end
					default: begin
						st_d = stws_pkg::ST_RX;
					end
					endcase
				end
			end
			stws_pkg::ST_TX: begin
				if (scl_rise && !oe_q && !sda_in &&
					kind_q == stws_pkg::KIND_ARA) begin
					// Another responder drove low: stop driving
					lost_d = 1'b1; // see RL7
				end
				if (scl_fall) begin
					// Shift on the last fall too, so the low byte ends on top
					tx_d = {tx_q[14:0], 1'b0};
					if (bit_q == 4'h7) begin
						bit_d = 4'h0;
						oe_d = 1'b0;
						st_d = stws_pkg::ST_TX_ACK;
					end else begin
						bit_d = bit_q + 4'h1;
						oe_d = !tx_q[14] && !lost_d;
					end
				end
			end
			stws_pkg::ST_TX_ACK: begin
				if (scl_rise) begin
					if (kind_q == stws_pkg::KIND_ARA) begin
						clr_d = !lost_q; // see RL7
						st_d = stws_pkg::ST_IDLE;
					end else if (sda_in) begin
						st_d = stws_pkg::ST_IDLE; // see RL3
					end
				end
				if (scl_fall && kind_q == stws_pkg::KIND_READ) begin
					// Low byte follows; later bytes repeat the register
					st_d = stws_pkg::ST_TX; // see RL16
					if (!byte2_q) begin
						byte2_d = 1'b1; // see RL2
						oe_d = !tx_q[15];
					end else begin
						byte2_d = 1'b0;
						tx_d = reg_data_in; // see RL19
						oe_d = !reg_data_in[15];
					end
				end
			end
			default: st_d = stws_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			st_q <= stws_pkg::ST_IDLE;
			kind_q <= stws_pkg::KIND_NONE;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			sh_q <= 8'h00;
			bit_q <= 4'h0;
			tx_q <= 16'h0000;
			byte2_q <= 1'b0;
			busy_q <= 1'b0;
			pin_q <= 1'b0;
			oe_q <= 1'b0;
			lost_q <= 1'b0;
			gc_cmd_q <= 1'b0;
			rd_q <= 1'b0;
			clr_q <= 1'b0;
			rst_q <= 1'b0;
		end else begin
			st_q <= st_d;
			kind_q <= kind_d;
			scl_q <= scl_in;
			sda_q <= sda_in;
			sh_q <= sh_d;
			bit_q <= bit_d;
			tx_q <= tx_d;
			byte2_q <= byte2_d;
			busy_q <= busy_d;
			pin_q <= pin_d;
			oe_q <= oe_d;
			lost_q <= lost_d;
			gc_cmd_q <= gc_cmd_d;
			rd_q <= rd_d;
			clr_q <= clr_d;
			rst_q <= rst_d;
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe_out = oe_q;
	assign reg_read_out = rd_q;
	assign alarm_clear_out = clr_q;
	assign regs_reset_out = rst_q;
	assign busy_out = busy_q;

	timeout_release_a: assert property (@(posedge clk_in)
		disable iff (!rst_n_in) tmo |=> !sda_oe_out && !busy_out) // see RL12
		else $error("bus not released after timeout");
	start_busy_a: assert property (@(posedge clk_in)
		disable iff (!rst_n_in) start_ev && !tmo |=> busy_out) // see RL14
		else $error("start not recognised");
	stop_idle_a: assert property (@(posedge clk_in)
		disable iff (!rst_n_in) stop_ev && !tmo |=> !busy_out) // see RL15
		else $error("stop not recognised");
	ack_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		st_q == stws_pkg::ST_ACK && sda_oe_out && !scl_fall && !start_ev
		&& !stop_ev && !tmo |=> sda_oe_out) // see RL17
		else $error("ack released early");
	clear_win_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		alarm_clear_out |-> $past(kind_q, 2) == stws_pkg::KIND_ARA) // see RL7
		else $error("alarm cleared outside alert response");
	ara_gate_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(kind_q == stws_pkg::KIND_ARA) |-> $past(alarm_in)) // see RL5
		else $error("alert answered without alarm");
	read_pulse_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		reg_read_out |-> kind_q == stws_pkg::KIND_READ
		&& st_q == stws_pkg::ST_TX) // see RL19
		else $error("read pulse out of place");
	gc_reset_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		regs_reset_out |-> $past(kind_q, 1) == stws_pkg::KIND_GCALL
		&& $past(sh_q, 1) == `STWS_GC_RESET) // see RL10
		else $error("register reset without command");
	idle_quiet_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		st_q == stws_pkg::ST_IDLE |-> !sda_oe_out) // see RL22
		else $error("data driven while idle");
	lost_quiet_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		lost_q && kind_q == stws_pkg::KIND_ARA && st_q == stws_pkg::ST_TX
		|-> !sda_oe_out) // see RL7
		else $error("data driven after lost arbitration");
endmodule

// >>> verif/stws_master.sv
// Behavioural two-wire bus master that drives the slave bench
`timescale 1ns/1ps
module stws_master (
	input wire logic clk_in, // System clock
	input wire logic sda_in, // Resolved data line
	output logic scl_out, // Bus clock, idles high
	output logic sda_low_out // High while pulling data low
);
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end
	// Four system clocks per quarter bit keeps SCL far above 1 kHz
	task automatic q();
		repeat (4) @(posedge clk_in);
		#1;
	endtask
	// Releases SDA first so that it also serves as a repeated start
	task automatic start();
		sda_low_out = 1'b0;
		q();
		scl_out = 1'b1;
		q();
		sda_low_out = 1'b1;
		q();
		scl_out = 1'b0;
		q();
	endtask
	task automatic stop();
		sda_low_out = 1'b1;
		q();
		scl_out = 1'b1;
		q();
		sda_low_out = 1'b0;
		q();
	endtask
	// Data moves only while SCL is low; sampled in the high phase
	task automatic bit_x(input logic b, output logic r);
		sda_low_out = !b;
		q();
		scl_out = 1'b1;
		q();
		r = sda_in;
		q();
		scl_out = 1'b0;
		q();
	endtask
	// Eight bits MSB first, then the acknowledge slot
	task automatic byte_x(input logic [7:0] tx, input logic ack,
		output logic [7:0] rx, output logic ackr);
		for (int i = 7; i >= 0; i--) begin
			bit_x(tx[i], rx[i]);
		end
		bit_x(ack, ackr);
	endtask
endmodule

// >>> verif/sensor_two_wire_slave_alert_tb.sv
// Self-checking bench for the two-wire slave with alert response
`timescale 1ns/1ps
module sensor_two_wire_slave_alert_tb;
	logic clk_in, rst_n_in, scl, sda_low, pin, alarm, alarm_high;
	logic [15:0] reg_data;
	logic sda_o, sda_oe, reg_read, alarm_clear, regs_reset, busy;
	int error_cnt = 0, cmp_count = 0, n_read = 0, n_clear = 0, n_reset = 0;
	wire sda_line;
	// Pull-up: line is low only while someone pulls it
	assign sda_line = !sda_low && !(sda_oe && !sda_o);
	stws_master m (.clk_in(clk_in), .sda_in(sda_line), .scl_out(scl),
		.sda_low_out(sda_low));
	stws_slave #(.TIMEOUT_CYC(400)) dut (.clk_in(clk_in),
		.rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda_line),
		.sda_out(sda_o), .sda_oe_out(sda_oe),
		.address_select_pin_in(pin), .reg_index_in(8'h00),
		.reg_data_in(reg_data), .alarm_in(alarm),
		.alarm_high_in(alarm_high), .reg_read_out(reg_read),
		.alarm_clear_out(alarm_clear), .regs_reset_out(regs_reset),
		.busy_out(busy));
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		if (reg_read === 1'b1) n_read++;
		if (alarm_clear === 1'b1) n_clear++;
		if (regs_reset === 1'b1) n_reset++;
	end
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk8(input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value at %0t exp %h got %h", $time, e, g);
		end
	endtask
	task automatic chk1(input logic e, input logic g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value at %0t exp %h got %h", $time, e, g);
		end
	endtask
	task automatic addr(input logic [7:0] ad, input logic ea);
		logic [7:0] rx;
		logic a;
		m.start();
		chk1(1'b1, busy);
		m.byte_x(ad, 1'b1, rx, a);
		chk1(ea, a);
	endtask
	task automatic rd(input logic ack, input logic [7:0] tx,
		input logic [7:0] e);
		logic [7:0] rx;
		logic a;
		m.byte_x(tx, ack, rx, a);
		chk8(e, rx);
	endtask
	task automatic t_read();
		int r;
		pin = 1'b0;
		reg_data = 16'ha5c3;
		r = n_read;
		addr(8'h91, 1'b0);
		rd(1'b0, 8'hff, 8'ha5);
		chk1(1'b1, n_read == r + 1);
		rd(1'b0, 8'hff, 8'hc3);
		rd(1'b1, 8'hff, 8'ha5);
		m.stop();
		chk1(1'b0, busy);
		pin = 1'b1;
		addr(8'h93, 1'b0);
		rd(1'b1, 8'hff, 8'ha5);
		m.stop();
		addr(8'h91, 1'b1);
		m.stop();
		$display("test read done");
	endtask
	task automatic t_alert();
		int c;
		pin = 1'b0;
		alarm = 1'b1;
		for (int h = 1; h >= 0; h--) begin
			alarm_high = h[0];
			c = n_clear;
			addr(8'h19, 1'b0);
			rd(1'b1, 8'hff, {7'h48, h[0]});
			m.stop();
			chk1(1'b1, n_clear == c + 1);
		end
		// A rival device with a lower address wins the byte
		c = n_clear;
		addr(8'h19, 1'b0);
		rd(1'b1, 8'h80, 8'h80);
		m.stop();
		chk1(1'b1, n_clear == c);
		alarm = 1'b0;
		addr(8'h19, 1'b1);
		m.stop();
		$display("test alert done");
	endtask
	task automatic t_gcall();
		int r;
		logic [7:0] rx;
		logic a;
		r = n_reset;
		addr(8'h00, 1'b0);
		m.byte_x(8'h04, 1'b1, rx, a);
		chk1(1'b0, a);
		m.stop();
		chk1(1'b1, n_reset == r);
		addr(8'h00, 1'b0);
		m.byte_x(8'h06, 1'b1, rx, a);
		chk1(1'b0, a);
		m.stop();
		chk1(1'b1, n_reset == r + 1);
		$display("test general call done");
	endtask
	task automatic t_timeout();
		logic [7:0] rx;
		logic a;
		reg_data = 16'h0000;
		addr(8'h91, 1'b0);
		chk1(1'b1, sda_oe);
		// SCL held low well past the shortened limit of 400 cycles
		repeat (500) @(posedge clk_in);
		#1;
		chk1(1'b0, sda_oe);
		chk1(1'b0, busy);
		m.byte_x(8'h91, 1'b1, rx, a);
		chk1(1'b1, a);
		m.stop();
		$display("test timeout done");
	endtask
	initial begin
		repeat (20000) @(posedge clk_in);
		error_cnt++;
		report_and_stop();
	end
	initial begin
		rst_n_in = 1'b0;
		pin = 1'b0;
		alarm = 1'b0;
		alarm_high = 1'b0;
		reg_data = 16'h0000;
		repeat (3) @(posedge clk_in);
		#1;
		rst_n_in = 1'b1;
		@(posedge clk_in);
		#1;
		t_read();
		t_alert();
		t_gcall();
		t_timeout();
		report_and_stop();
	end
endmodule
